// File: rtl/ftfc_map.vh
`ifndef FTFC_MAP_VH
`define FTFC_MAP_VH
// Register word indexes and the address width (byte address is index times four).
`define FTFC_IDX_ALARM      8'h03
`define FTFC_IDX_FEATURE    8'h04
`define FTFC_IDX_IRQ_STATUS 8'h12
`define FTFC_IDX_IRQ_MASK   8'h13
`define FTFC_IDX_MODE       8'h14
`define FTFC_IDX_STATUS     8'h15
`define FTFC_ADDR_W         8
// Feature control field positions.
`define FTFC_FC_TEST_EQ     7
`define FTFC_FC_AMI         6
`define FTFC_FC_ENC_DIS     5
`define FTFC_FC_SAT_DIS     4
`define FTFC_FC_PAR_EN      3
`define FTFC_FC_PAT_HI      2
`define FTFC_FC_PAT_LO      0
// Mode register field positions.
`define FTFC_MODE_CBIT      0
`define FTFC_MODE_E3        1
// Interrupt status bit positions.
`define FTFC_IRQ_ALARM      1
`define FTFC_IRQ_LCV        2
`define FTFC_IRQ_FERR       3
// Reset values.
`define FTFC_ALARM_RST      8'hFF
`define FTFC_FEATURE_RST    8'h07
`define FTFC_MODE_RST       8'h00
`define FTFC_IRQ_RST        8'h00
// Alarm channel framing.
`define FTFC_FLAG_BYTE      8'h7E
`define FTFC_IDLE_BYTE      8'hFF
`define FTFC_BIT_CNT_W      3
`define FTFC_BIT_LAST       3'h7
// AXI responses.
`define FTFC_RESP_OKAY      2'h0
`define FTFC_RESP_SLVERR    2'h2
`endif

// File: rtl/ftfc_err_counter.v
`timescale 1ns/1ps
`default_nettype none
// Saturating or wrapping error counter with carry pulse.
module ftfc_err_counter #(
   parameter W = 16
) (
   input  wire         clk,     // Clock.
   input  wire         rst,     // Asynchronous reset.
   input  wire         ce,      // Clock enable.
   input  wire         event_i, // Error event.
   input  wire         clear,   // Clear count.
   input  wire         sat_dis, // Wrap instead of saturate.
   output reg  [W-1:0] count_q, // Count value.
   output reg          carry_q, // One-cycle rollover pulse.
   output reg          full_q   // Saturation event pulse.
);
   wire at_max = &count_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= {W{1'b0}};
         carry_q <= 1'b0;
         full_q  <= 1'b0;
      end else if (ce) begin
         carry_q <= 1'b0;
         full_q  <= 1'b0;
         if (clear) begin
            count_q <= {W{1'b0}};
         end else if (event_i) begin
            if (!at_max) begin
               count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
               full_q  <= (count_q == {{(W-1){1'b1}}, 1'b0}) & ~sat_dis;
            end else if (sat_dis) begin
               count_q <= {W{1'b0}};
               carry_q <= 1'b1;
            end
         end
      end
   end
endmodule // ftfc_err_counter
`default_nettype wire

// File: rtl/ftfc_top.v
// Summary of operation
// - In C-bit mode the alarm channel byte register feeds the alarm transmitter.
// - Byte with MSB and LSB zero is sent after every flag, repeatedly.
// - MSB or LSB set sends all ones and suppresses transmitter interrupts.
// - Any write to the alarm byte clears the alarm channel interrupt flag.
// - Test-equipment select gives direct encoder input and violation insertion pins.
// - AMI bit gives plain AMI rails without zero substitution.
// - With test-equipment select, AMI bit picks the inserted violation type.
// - Encoder disable sends NRZ on positive rail, line clock on negative rail.
// - Saturation disable lets counters wrap, no interrupt, carries show rollover.
// - Parallel enable moves packet link data as bytes on parallel buses.
// - Parallel enable in E3 mode alters the transmitted overhead field.
// - Parallel enable low uses serial input and serial output for the stream.
// - In C-bit mode the 3-bit block error pattern is sent when due.
// - Block error pattern goes out automatically on F-bit or parity error.
// - All-ones pattern disables block error indications.
`timescale 1ns/1ps
`default_nettype none
`include "ftfc_map.vh"
module ftfc_top #(
   parameter CNT_W = 16
) (
   input  wire        clk,                     // 10 MHz clock.
   input  wire        rst,                     // Asynchronous reset, active high.
   input  wire        ce,                      // Clock enable, freezes state when low.
   input  wire [7:0]  s_axi_awaddr,            // Write address.
   input  wire        s_axi_awvalid,           // Write address valid.
   output wire        s_axi_awready,           // Write address ready.
   input  wire [31:0] s_axi_wdata,             // Write data.
   input  wire [3:0]  s_axi_wstrb,             // Write strobes.
   input  wire        s_axi_wvalid,            // Write data valid.
   output wire        s_axi_wready,            // Write data ready.
   output reg  [1:0]  s_axi_bresp,             // Write response.
   output reg         s_axi_bvalid,            // Write response valid.
   input  wire        s_axi_bready,            // Write response ready.
   input  wire [7:0]  s_axi_araddr,            // Read address.
   input  wire        s_axi_arvalid,           // Read address valid.
   output wire        s_axi_arready,           // Read address ready.
   output reg  [31:0] s_axi_rdata,             // Read data.
   output reg  [1:0]  s_axi_rresp,             // Read response.
   output reg         s_axi_rvalid,            // Read data valid.
   input  wire        s_axi_rready,            // Read data ready.
   output wire        irq,                     // Level interrupt.
   input  wire        tx_bit_strobe,           // One alarm channel bit slot due.
   output reg         far_end_alarm_channel,   // Alarm channel serial bit.
   input  wire        block_error_due,         // Block error slot is due.
   input  wire        rx_fbit_error,           // Receiver saw an F-bit error.
   input  wire        rx_parity_error,         // Receiver saw a path parity error.
   output reg  [2:0]  far_end_block_error,     // Block error bits for the frame.
   output reg         far_end_block_error_vld, // Block error bits valid.
   input  wire        line_clk_in,             // Line input clock level.
   input  wire        tx_data_bit,             // Framed stream bit to encode.
   input  wire        tx_zero_sub_pos,         // Substituted positive pulse.
   input  wire        tx_zero_sub_neg,         // Substituted negative pulse.
   input  wire        tx_serial_input,         // Serial stream input.
   output reg         rx_serial_output,        // Serial stream output.
   input  wire        rx_stream_bit,           // Received stream bit.
   input  wire [7:0]  tx_parallel_bus,         // Parallel transmit bus.
   output reg  [7:0]  rx_parallel_bus,         // Parallel receive bus.
   input  wire [7:0]  rx_packet_byte,          // Received packet link byte.
   output reg  [7:0]  packet_data_link,        // Packet link transmit byte.
   output reg         tx_stream_bit,           // Stream bit into the framer.
   output wire        e3_overhead_alter,       // Alter E3 overhead for parallel use.
   input  wire        line_code_violation,     // Received violation event.
   input  wire        frame_error,             // Received frame error event.
   output wire        lcv_carry,               // Violation counter rollover.
   output wire        ferr_carry,              // Frame error counter rollover.
   output reg         tx_positive_rail,        // Positive rail output.
   output reg         tx_negative_rail         // Negative rail output.
);
   reg  [7:0] alarm_q;
   reg  [7:0] feature_q;
   reg  [1:0] mode_q;
   reg  [7:0] irq_stat_q;
   reg  [7:0] irq_mask_q;
   reg        aw_hold_q;
   reg        w_hold_q;
   reg  [7:0] awaddr_q;
   reg  [7:0] wdata_q;
   reg        wstrb_q;
   wire       cbit  = mode_q[`FTFC_MODE_CBIT];
   wire       e3    = mode_q[`FTFC_MODE_E3];
   wire       t_eq  = feature_q[`FTFC_FC_TEST_EQ];
   wire       ami   = feature_q[`FTFC_FC_AMI];
   wire       e_dis = feature_q[`FTFC_FC_ENC_DIS];
   wire       s_dis = feature_q[`FTFC_FC_SAT_DIS];
   wire       p_en  = feature_q[`FTFC_FC_PAR_EN];
   wire [2:0] pat   = feature_q[`FTFC_FC_PAT_HI:`FTFC_FC_PAT_LO];

   // Address and data are latched independently so either may come first.
   assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire  = s_axi_wvalid & s_axi_wready;
   wire have_aw = aw_hold_q | aw_fire;
   wire have_w  = w_hold_q | w_fire;
   wire [7:0] wa = aw_fire ? s_axi_awaddr : awaddr_q;
   wire [7:0] wd = w_fire ? s_axi_wdata[7:0] : wdata_q;
   wire       ws = w_fire ? s_axi_wstrb[0] : wstrb_q;
   wire       wr_go = have_aw & have_w & ce;
   wire [5:0] w_idx = wa[7:2];
   wire       w_alarm = wr_go & ws & (w_idx == `FTFC_IDX_ALARM);
   wire       w_feat  = wr_go & ws & (w_idx == `FTFC_IDX_FEATURE);
   wire       w_stat  = wr_go & ws & (w_idx == `FTFC_IDX_IRQ_STATUS);
   wire       w_mask  = wr_go & ws & (w_idx == `FTFC_IDX_IRQ_MASK);
   wire       w_mode  = wr_go & ws & (w_idx == `FTFC_IDX_MODE);
   wire       w_known = (w_idx == `FTFC_IDX_ALARM) | (w_idx == `FTFC_IDX_FEATURE) |
                        (w_idx == `FTFC_IDX_IRQ_STATUS) | (w_idx == `FTFC_IDX_IRQ_MASK) |
                        (w_idx == `FTFC_IDX_MODE);

   // Alarm channel transmitter: a flag, then the byte or idle ones, LSB first.
   reg                       phase_q;
   reg  [`FTFC_BIT_CNT_W-1:0] bit_q;
   reg  [7:0]                shift_q;
   wire alarm_idle = alarm_q[7] | alarm_q[0];
   wire byte_done  = ce & cbit & tx_bit_strobe & (bit_q == `FTFC_BIT_LAST) & phase_q;
   wire alarm_evt  = byte_done & ~alarm_idle;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= 1'b0;
         bit_q   <= {`FTFC_BIT_CNT_W{1'b0}};
         shift_q <= `FTFC_FLAG_BYTE;
         far_end_alarm_channel <= 1'b1;
      end else if (ce) begin
         if (!cbit) begin
            far_end_alarm_channel <= 1'b1;
            phase_q <= 1'b0;
            bit_q   <= {`FTFC_BIT_CNT_W{1'b0}};
            shift_q <= `FTFC_FLAG_BYTE;
         end else if (tx_bit_strobe) begin
            far_end_alarm_channel <= shift_q[0];
            bit_q <= bit_q + 3'h1;
            if (bit_q == `FTFC_BIT_LAST) begin
               phase_q <= ~phase_q;
               if (!phase_q)
                  shift_q <= alarm_idle ? `FTFC_IDLE_BYTE : alarm_q;
               else
                  shift_q <= `FTFC_FLAG_BYTE;
            end else begin
               shift_q <= {1'b1, shift_q[7:1]};
            end
         end
      end
   end

   // Block error insertion.
   wire fbe_enable = cbit & (pat != 3'h7);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         far_end_block_error     <= 3'h7;
         far_end_block_error_vld <= 1'b0;
      end else if (ce) begin
         far_end_block_error_vld <= 1'b0;
         far_end_block_error     <= 3'h7;
         if (block_error_due & fbe_enable & (rx_fbit_error | rx_parity_error)) begin
            far_end_block_error     <= pat;
            far_end_block_error_vld <= 1'b1;
         end
      end
   end

   // Line encoder output stage.
   reg enc_bit;
   reg alt_q;
   always @* begin
      enc_bit = t_eq ? tx_parallel_bus[5] : tx_data_bit;
   end
   wire viol = t_eq & tx_parallel_bus[4];
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         alt_q            <= 1'b0;
         tx_positive_rail <= 1'b0;
         tx_negative_rail <= 1'b0;
      end else if (ce) begin
         if (e_dis) begin
            tx_positive_rail <= enc_bit;
            tx_negative_rail <= line_clk_in;
         end else if (viol) begin
            // Type 2 repeats polarity on a one; type 1 inserts a pulse on a zero slot.
            tx_positive_rail <= ami ? (enc_bit & alt_q) : alt_q;
            tx_negative_rail <= ami ? (enc_bit & ~alt_q) : ~alt_q;
         end else if (ami & ~t_eq) begin
            tx_positive_rail <= enc_bit & ~alt_q;
            tx_negative_rail <= enc_bit & alt_q;
            if (enc_bit)
               alt_q <= ~alt_q;
         end else begin
            tx_positive_rail <= (enc_bit & ~alt_q) | tx_zero_sub_pos;
            tx_negative_rail <= (enc_bit & alt_q) | tx_zero_sub_neg;
            if (enc_bit | tx_zero_sub_pos | tx_zero_sub_neg)
               alt_q <= ~alt_q;
         end
      end
   end

   // Stream path selection.
   assign e3_overhead_alter = p_en & e3;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_stream_bit    <= 1'b0;
         rx_serial_output <= 1'b0;
         rx_parallel_bus  <= 8'h00;
         packet_data_link <= 8'h00;
      end else if (ce) begin
         if (p_en) begin
            packet_data_link <= tx_parallel_bus;
            rx_parallel_bus  <= rx_packet_byte;
         end else begin
            tx_stream_bit    <= tx_serial_input;
            rx_serial_output <= rx_stream_bit;
         end
      end
   end

   // Error counters.
   wire lcv_full;
   wire ferr_full;
   ftfc_err_counter #(.W(CNT_W)) u_lcv (
      .clk(clk), .rst(rst), .ce(ce), .event_i(line_code_violation), .clear(1'b0),
      .sat_dis(s_dis), .count_q(), .carry_q(lcv_carry), .full_q(lcv_full));
   ftfc_err_counter #(.W(CNT_W)) u_ferr (
      .clk(clk), .rst(rst), .ce(ce), .event_i(frame_error), .clear(1'b0),
      .sat_dis(s_dis), .count_q(), .carry_q(ferr_carry), .full_q(ferr_full));

   // Register file and AXI write channel.
   wire [7:0] evt = {4'h0, ferr_full, lcv_full, alarm_evt, 1'b0};
   wire [7:0] clr = (w_stat ? wd : 8'h00) | (w_alarm ? (8'h01 << `FTFC_IRQ_ALARM) : 8'h00);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm_q      <= `FTFC_ALARM_RST;
         feature_q    <= `FTFC_FEATURE_RST;
         mode_q       <= 2'h0;
         irq_stat_q   <= `FTFC_IRQ_RST;
         irq_mask_q   <= `FTFC_IRQ_RST;
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 8'h00;
         wstrb_q      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `FTFC_RESP_OKAY;
      end else if (ce) begin
         irq_stat_q <= (irq_stat_q & ~clr) | evt;
         if (w_alarm)
            alarm_q <= wd;
         if (w_feat)
            feature_q <= wd;
         if (w_mask)
            irq_mask_q <= wd;
         if (w_mode)
            mode_q <= wd[1:0];
         if (wr_go) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_known ? `FTFC_RESP_OKAY : `FTFC_RESP_SLVERR;
         end else begin
            if (aw_fire) begin
               aw_hold_q <= 1'b1;
               awaddr_q  <= s_axi_awaddr;
            end
            if (w_fire) begin
               w_hold_q <= 1'b1;
               wdata_q  <= s_axi_wdata[7:0];
               wstrb_q  <= s_axi_wstrb[0];
            end
            if (s_axi_bvalid & s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // AXI read channel.
   wire [5:0] r_idx = s_axi_araddr[7:2];
   reg  [7:0] rmux;
   reg        r_ok;
   always @* begin
      r_ok = 1'b1;
      case (r_idx)
         `FTFC_IDX_ALARM:      rmux = alarm_q;
         `FTFC_IDX_FEATURE:    rmux = feature_q;
         `FTFC_IDX_IRQ_STATUS: rmux = irq_stat_q;
         `FTFC_IDX_IRQ_MASK:   rmux = irq_mask_q;
         `FTFC_IDX_MODE:       rmux = {6'h00, mode_q};
         `FTFC_IDX_STATUS:     rmux = {5'h00, alarm_idle, fbe_enable, phase_q};
         default: begin
            rmux = 8'h00;
            r_ok = 1'b0;
         end
      endcase
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `FTFC_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rmux};
            s_axi_rresp  <= r_ok ? `FTFC_RESP_OKAY : `FTFC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ftfc_top
`default_nettype wire

// File: tb/ftfc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ftfc_props #(
   parameter CNT_W = 16
) (
   input wire logic        clk,                     // Clock.
   input wire logic        rst,                     // Reset.
   input wire logic        s_axi_bvalid,            // Write response valid.
   input wire logic        s_axi_bready,            // Write response ready.
   input wire logic        s_axi_rvalid,            // Read valid.
   input wire logic        s_axi_rready,            // Read ready.
   input wire logic [31:0] s_axi_rdata,             // Read data.
   input wire logic        block_error_due,         // Block error slot.
   input wire logic        rx_fbit_error,           // F-bit error.
   input wire logic        rx_parity_error,         // Parity error.
   input wire logic [2:0]  far_end_block_error,     // Block error bits.
   input wire logic        far_end_block_error_vld, // Block error valid.
   input wire logic        line_code_violation,     // Violation event.
   input wire logic        frame_error,             // Frame error event.
   input wire logic        lcv_carry,               // Violation rollover.
   input wire logic        ferr_carry,              // Frame rollover.
   input wire logic        e3_overhead_alter        // Overhead alter level.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped early");
   rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data wider than a byte");
   far_end_block_error_pattern_a: assert property (far_end_block_error_vld |-> far_end_block_error != 3'h7)
      else $error("all-ones block error sent");
   far_end_block_error_cause_a: assert property (far_end_block_error_vld |->
      $past(block_error_due && (rx_fbit_error || rx_parity_error))) else $error("block error without cause");
   far_end_block_error_idle_a: assert property (!far_end_block_error_vld |-> far_end_block_error == 3'h7)
      else $error("block error bits not idle");
   lcv_carry_a: assert property (lcv_carry |-> $past(line_code_violation) ##1 !lcv_carry)
      else $error("violation carry malformed");
   ferr_carry_a: assert property (ferr_carry |-> $past(frame_error) ##1 !ferr_carry)
      else $error("frame carry malformed");
   overhead_write_a: assert property ($changed(e3_overhead_alter) |-> $rose(s_axi_bvalid))
      else $error("overhead alter moved without a write");
   cover property (far_end_block_error_vld);
   cover property (lcv_carry);
   cover property ($rose(e3_overhead_alter));
endmodule // ftfc_props
bind ftfc_top ftfc_props #(.CNT_W(CNT_W)) u_props (.clk, .rst, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .block_error_due, .rx_fbit_error, .rx_parity_error,
   .far_end_block_error, .far_end_block_error_vld, .line_code_violation, .frame_error, .lcv_carry,
   .ferr_carry, .e3_overhead_alter);
`default_nettype wire

// File: tb/ftfc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ftfc_far_model (
   input  wire logic       clk,      // Clock.
   input  wire logic       rst,      // Reset.
   input  wire logic       slow,     // Stretch the bit slot spacing.
   input  wire logic       line_bit, // Alarm channel bit from the framer.
   output logic            strobe,   // Bit slot pulse.
   output logic      [7:0] got       // Last byte that followed a flag.
);
   logic [3:0]  cnt_q;
   logic        smp_q;
   logic [15:0] sh_q;
   // The bit is taken one cycle after the slot so the framer's register has landed.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         strobe <= 1'b0;
         smp_q <= 1'b0;
         sh_q <= 16'hFFFF;
         got <= 8'h00;
      end else begin
         cnt_q <= (cnt_q >= (slow ? 4'h8 : 4'h2)) ? 4'h0 : cnt_q + 4'h1;
         strobe <= (cnt_q == 4'h0);
         smp_q <= strobe;
         if (smp_q) sh_q <= {line_bit, sh_q[15:1]};
         if (sh_q[7:0] == 8'h7E) got <= sh_q[15:8];
      end
   end
endmodule // ftfc_far_model
`default_nettype wire

// File: tb/framer_tx_feature_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftfc_map.vh"
module framer_tx_feature_control_tb_top;
   localparam logic [7:0] A_AL = 8'h0C, A_FC = 8'h10, A_ST = 8'h48, A_MK = 8'h4C, A_MD = 8'h50;
   logic        clk, rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, block_error_due, rx_fbit_error, rx_parity_error, line_clk_in;
   logic        tx_data_bit, tx_zero_sub_pos, tx_zero_sub_neg, tx_serial_input, rx_stream_bit;
   logic        line_code_violation, frame_error, slow, hv, lp;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_parallel_bus, rx_packet_byte, v;
   logic [31:0] s_axi_wdata, rd, r;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  rsp;
   wire         s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, irq;
   wire         tx_bit_strobe, far_end_alarm_channel, far_end_block_error_vld, rx_serial_output;
   wire         tx_stream_bit, e3_overhead_alter, lcv_carry, ferr_carry;
   wire         tx_positive_rail, tx_negative_rail;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire [2:0]   far_end_block_error;
   wire [7:0]   rx_parallel_bus, packet_data_link, got;
   int          err_total, tests_run, n_lcv, n_ferr;
   // A four-bit counter keeps the wrap test short.
   ftfc_top #(.CNT_W(4)) uut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq, .tx_bit_strobe, .far_end_alarm_channel,
      .block_error_due, .rx_fbit_error, .rx_parity_error, .far_end_block_error,
      .far_end_block_error_vld, .line_clk_in, .tx_data_bit, .tx_zero_sub_pos, .tx_zero_sub_neg,
      .tx_serial_input, .rx_serial_output, .rx_stream_bit, .tx_parallel_bus, .rx_parallel_bus,
      .rx_packet_byte, .packet_data_link, .tx_stream_bit, .e3_overhead_alter,
      .line_code_violation, .frame_error, .lcv_carry, .ferr_carry, .tx_positive_rail,
      .tx_negative_rail);
   ftfc_far_model far (.clk(clk), .rst(rst), .slow(slow), .line_bit(far_end_alarm_channel),
      .strobe(tx_bit_strobe), .got(got));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (lcv_carry === 1'b1) n_lcv++;
      if (ferr_carry === 1'b1) n_ferr++;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Ready and valid are looked at mid-cycle, so the edge that takes them is never raced.
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw;
      {pa, pw} = 2'b11;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw) begin
         @(negedge clk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         @(posedge clk);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      @(posedge clk);
   endtask
   task rd_t(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
   endtask
   task waitbyte(input logic [7:0] b);
      for (int n = 0; n < 800 && got !== b; n++) @(posedge clk);
   endtask
   task pulse(input int n);
      repeat (n) begin
         line_code_violation <= 1'b1;
         frame_error <= 1'b1;
         @(posedge clk);
         line_code_violation <= 1'b0;
         frame_error <= 1'b0;
         @(posedge clk);
      end
   endtask
   initial begin
      #2000000;
      err_total++;
      summarize;
   end
   initial begin
      {clk, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, block_error_due, rx_fbit_error} = 6'h00;
      {rx_parity_error, line_clk_in, tx_data_bit, tx_zero_sub_pos, tx_zero_sub_neg} = 5'h00;
      {tx_serial_input, rx_stream_bit, line_code_violation, frame_error, slow} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, tx_parallel_bus, rx_packet_byte, s_axi_wdata} = 64'h0;
      {rst, ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 8'hFF;
      {err_total, tests_run, n_lcv, n_ferr} = 128'h0;
      r = $urandom(13828);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_t(A_AL); chk(rd, `FTFC_ALARM_RST);
      rd_t(A_FC); chk(rd, `FTFC_FEATURE_RST);
      rd_t(8'h08);
      chk(rd, 32'h0);
      chk(rsp, `FTFC_RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         wr(i[0] ? A_FC : A_AL, r);
         rd_t(i[0] ? A_FC : A_AL); chk(rd, {24'h0, r[7:0]});
      end
      wr(A_MK, 32'h02);
      wr(A_MD, 32'h01);
      for (int i = 0; i < 2; i++) begin
         slow <= i[0];
         v = ($urandom & 8'h38) | (i[0] ? 8'h04 : 8'h02);
         wr(A_AL, v);
         waitbyte(v); chk(got, v);
         rd_t(A_ST); chk({rd[1], irq}, 2'h3);
      end
      wr(A_AL, 32'h81);
      waitbyte(`FTFC_IDLE_BYTE); chk(got, `FTFC_IDLE_BYTE);
      wr(A_AL, 32'h01);
      rd_t(A_ST); chk({rd[1], irq}, 2'h0);
      repeat (300) @(posedge clk);
      rd_t(A_ST); chk({got, rd[1], irq}, {`FTFC_IDLE_BYTE, 2'h0});
      for (int p = 0; p < 8; p++) begin
         wr(A_FC, p);
         block_error_due <= 1'b1;
         rx_fbit_error <= p[0];
         rx_parity_error <= !p[0];
         @(posedge clk);
         block_error_due <= 1'b0;
         #1 chk({far_end_block_error_vld, far_end_block_error}, (p == 7) ? 4'h7 : {1'b1, p[2:0]});
         @(posedge clk);
      end
      wr(A_FC, 32'h20);
      repeat (16) begin
         r = $urandom;
         {tx_data_bit, line_clk_in, tx_zero_sub_pos, tx_zero_sub_neg} <= r[3:0];
         @(posedge clk);
         #1 chk({tx_positive_rail, tx_negative_rail}, r[3:2]);
         @(posedge clk);
      end
      wr(A_FC, 32'h40);
      hv = 1'b0;
      repeat (16) begin
         r = $urandom;
         {tx_data_bit, tx_zero_sub_pos, tx_zero_sub_neg} <= r[2:0];
         @(posedge clk);
         #1 chk(tx_positive_rail ^ tx_negative_rail, r[2]);
         if (r[2] && hv) chk(tx_positive_rail, !lp);
         if (r[2]) {hv, lp} = {1'b1, tx_positive_rail};
      end
      {tx_zero_sub_pos, tx_zero_sub_neg} <= 2'h0;
      for (int t = 0; t < 2; t++) begin
         wr(A_FC, t ? 32'hC0 : 32'h80);
         tx_parallel_bus <= 8'h20;
         @(posedge clk);
         #1 chk(tx_positive_rail ^ tx_negative_rail, 1'b1);
         lp = tx_positive_rail;
         tx_parallel_bus <= 8'h10;
         @(posedge clk);
         #1 chk({tx_positive_rail, tx_negative_rail}, t ? 2'b00 : {lp, !lp});
      end
      wr(A_MD, 32'h03);
      for (int m = 0; m < 2; m++) begin
         wr(A_FC, m ? 32'h08 : 32'h00);
         repeat (8) begin
            r = $urandom;
            {tx_serial_input, rx_stream_bit, rx_packet_byte, tx_parallel_bus} <= r[17:0];
            @(posedge clk);
            #1;
            if (m) chk({packet_data_link, rx_parallel_bus, e3_overhead_alter}, {r[7:0], r[15:8], 1'b1});
            else chk({tx_stream_bit, rx_serial_output, e3_overhead_alter}, {r[17:16], 1'b0});
            @(posedge clk);
         end
      end
      wr(A_MK, 32'h0C);
      wr(A_FC, 32'h10);
      pulse(17);
      rd_t(A_ST); chk({rd[3:2], irq, n_lcv[7:0], n_ferr[7:0]}, 19'h00101);
      wr(A_FC, 32'h00);
      pulse(17);
      rd_t(A_ST); chk({rd[3:2], irq, n_lcv[7:0], n_ferr[7:0]}, 19'h70101);
      summarize;
   end
endmodule // framer_tx_feature_control_tb_top
`default_nettype wire
